// *** design/mdt_defines.svh ***
`ifndef MDT_DEFINES_SVH
`define MDT_DEFINES_SVH

// Register indices as printed; byte address is four times the index.
`define MDT_IDX_RELOAD      8'ha0
`define MDT_IDX_EVENT       8'ha2
`define MDT_IDX_CONTROL     8'ha3
`define MDT_IDX_LIVE        8'ha4
`define MDT_ADDR_RELOAD     12'h280
`define MDT_ADDR_EVENT      12'h288
`define MDT_ADDR_CONTROL    12'h28c
`define MDT_ADDR_LIVE       12'h290

// Field positions.
`define MDT_EV_UFLOW        0
`define MDT_CTL_ENABLE      0
`define MDT_CTL_RESET       1
`define MDT_CTL_STOP_UF     2
`define MDT_CTL_STATUS      7

// Reset values.
`define MDT_RELOAD_RST      16'hffff
`define MDT_LIVE_RST        16'h0000

// Timing: tick period and settle delay, with cycle counts at 40 MHz.
`define MDT_CLK_HZ          40000000
`define MDT_TICK_US         1000
`define MDT_TICK_CYC        ((`MDT_CLK_HZ / 1000000) * `MDT_TICK_US)
`define MDT_SETTLE_US       200
`define MDT_SETTLE_CYC      ((`MDT_CLK_HZ / 1000000) * `MDT_SETTLE_US)

`endif

// *** design/mdt_pkg.sv ***
package mdt_pkg;
    typedef logic [15:0] mdt_count_t;
    typedef enum logic [1:0] {
        MDT_IDLE,
        MDT_RUN,
        MDT_HALTING,
        MDT_RESETTING
    } mdt_state_e;
endpackage

// *** design/mdt_tick_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
// Divides the bus clock down to a one-cycle pulse every TICK cycles.
// The prescaler restarts when run is low, so the first tick after a start
// arrives a full period later.
module mdt_tick_gen #(
    parameter int TICK = 40000
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic run,
    output logic      tick
);
    logic [31:0] cnt;
    wire         at_end = (cnt == 32'(TICK - 1));

    // Free count while running, one pulse at the wrap.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= 32'h0;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= run && at_end;
            if (!run || at_end) begin
                cnt <= 32'h0;
            end else begin
                cnt <= cnt + 32'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** design/mdt_timer.sv ***
// Summary of operation
// - Reload is 16 bits of 1 ms steps, reset FFFFh; zero is illegal.
// - Enabled timer loads reload value if counter is zero, and counts down once per tick.
// - Underflow sets the underflow flag, bit 0 of event source.
// - Irq indication follows the flag; software write clears the flag.
// - With stop-on-underflow, underflow halts timer and clears enable.
// - With stop-on-underflow, flag is delayed until timer fully halted.
// - Status bit 7 reads 1 while counting or halting, else 0.
// - Control bit 1 stops timer and reloads counter from reload value.
// - Counter-reset bit self-clears only after reset fully propagates.
// - Bit 0 starts and stops timer; stop keeps the count.
// - Read-only live count returns the counter, reset value zero.
// - Writing 1 clears a write-clear bit; writing 0 leaves it.
`timescale 1ns/1ps
`default_nettype none
`include "mdt_defines.svh"

// How the block hangs together.
//
// The register side is a plain APB slave with no wait states.  The
// answer flops capture pready, prdata and pslverr from the setup cycle, so
// every transfer completes in its first access cycle.  Writes take effect at
// the edge that ends that access cycle, which is why every register update
// below is qualified by pready as well as by the access decode.
//
// The counting side is a small sequencer with four states.  IDLE waits for
// the enable bit, RUN counts ticks, HALTING waits out the slow stop that the
// stop-on-underflow mode asks for, and RESETTING waits out the slow counter
// reset.  Both waits use the same settle counter, since the two can never be
// in progress at once.
//
// The tick comes from a separate prescaler that restarts whenever the
// sequencer leaves RUN.  A restart therefore always costs one full tick
// before the first decrement.  This trades a little accuracy on a restart
// for a counter that never decrements early after a pause.
//
// Underflow is taken as the tick that finds the counter at one, so the
// counter reads from the reload value down to one while the timer runs and
// never sits at zero in free-running mode.  In stop mode the counter is
// parked at zero, which also marks it for a reload on the next start.
//
// The underflow flag is sticky and write-one-to-clear.  A set and a clear in
// the same cycle resolve in favour of the set, so an event is never lost to
// a clear that software aimed at an older event.  The irq indication is a
// registered copy of the flag and carries the same value at all times.
//
// A reload write whose merged value would be zero is dropped without an
// error response.  Software that needs to know can read the value back.
//
// Limitations that a user must know:
//   - the live count output is one cycle behind the internal counter;
//   - the live count register is only coherent while the timer is stopped;
//   - the reload register must not be written while the reset bit reads one;
//   - the clock enable freezes the bus answer as well as the timer, so a
//     master must not start a transfer while the enable is held low.

module mdt_timer #(
    parameter int TICK_CYC   = `MDT_TICK_CYC,
    parameter int SETTLE_CYC = `MDT_SETTLE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output var mdt_pkg::mdt_count_t timer_live_count,
    output logic             timer_irq_indication
);
    import mdt_pkg::*;

    mdt_state_e  state;
    mdt_count_t  timer_reload_value;
    mdt_count_t  counter;
    logic        underflow_flag;
    logic        enable;
    logic        stop_on_underflow;
    logic        reset_bit;
    logic        status;
    logic [31:0] settle;
    logic        tick;

    // Access phase decode; the slave answers in the first access cycle.
    wire acc      = psel && penable;
    wire wr       = acc && pwrite;
    wire hit_rel  = (paddr == `MDT_ADDR_RELOAD);
    wire hit_ev   = (paddr == `MDT_ADDR_EVENT);
    wire hit_ctl  = (paddr == `MDT_ADDR_CONTROL);
    wire hit_live = (paddr == `MDT_ADDR_LIVE);
    wire mapped   = hit_rel || hit_ev || hit_ctl || hit_live;
    wire wr_rel   = wr && hit_rel;
    wire wr_ev    = wr && hit_ev && pstrb[0];
    wire wr_ctl   = wr && hit_ctl && pstrb[0];
    wire ev_clear = wr_ev && pwdata[`MDT_EV_UFLOW];

    // Reload write merges byte lanes; a zero result is refused so the
    // counter can never be parked at an illegal value.
    wire [7:0]  rel_hi    = pstrb[1] ? pwdata[15:8]
                                     : timer_reload_value[15:8];
    wire [7:0]  rel_lo    = pstrb[0] ? pwdata[7:0]
                                     : timer_reload_value[7:0];
    wire [15:0] rel_merge = {rel_hi, rel_lo};
    wire rel_ok = wr_rel && (pstrb[1:0] != 2'b00)
                  && (rel_merge != 16'h0000);

    wire ctl_reset = wr_ctl && pwdata[`MDT_CTL_RESET];
    wire counting  = (state == MDT_RUN);
    wire at_zero   = (counter == 16'h0001);
    wire uflow     = counting && tick && at_zero;
    wire settled   = (settle == 32'h0);

    // Read mux; reserved bits read as zero.
    wire [7:0] ctl_rd = {status, 4'h0, stop_on_underflow, reset_bit, enable};
    wire [31:0] rd_mux = hit_rel  ? {16'h0, timer_reload_value} :
                         hit_ev   ? {31'h0, underflow_flag} :
                         hit_ctl  ? {24'h0, ctl_rd} :
                         hit_live ? {16'h0, counter} : 32'h0;

    mdt_tick_gen #(
        .TICK (TICK_CYC)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .run     (counting),
        .tick    (tick)
    );

    // Bus answer registers.  Unmapped addresses give pslverr.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= psel && !penable;
            prdata  <= rd_mux;
            pslverr <= psel && !penable && !mapped;
        end
    end

    // Reload register; software holds off while reset_bit is high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_reload_value <= `MDT_RELOAD_RST;
        end else if (ce && rel_ok && pready) begin
            timer_reload_value <= rel_merge;
        end
    end

    // Control bits.  Enable drops itself on underflow in stop mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable            <= 1'b0;
            stop_on_underflow <= 1'b0;
        end else if (ce) begin
            if (uflow && stop_on_underflow) begin
                enable <= 1'b0;
            end else if (wr_ctl && pready) begin
                enable <= pwdata[`MDT_CTL_ENABLE];
            end
            if (wr_ctl && pready) begin
                stop_on_underflow <= pwdata[`MDT_CTL_STOP_UF];
            end
        end
    end

    // Main sequencer.  Halting and resetting both wait a settle interval,
    // which models the slow propagation software must poll for.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= MDT_IDLE;
            counter   <= `MDT_LIVE_RST;
            reset_bit <= 1'b0;
            status    <= 1'b0;
            settle    <= 32'h0;
        end else if (ce) begin
            if (ctl_reset && pready) begin
                state     <= MDT_RESETTING;
                reset_bit <= 1'b1;
                status    <= 1'b0;
                counter   <= timer_reload_value;
                settle    <= 32'(SETTLE_CYC - 1);
            end else begin
                case (state)
                    MDT_IDLE: begin
                        status <= 1'b0;
                        if (enable) begin
                            state  <= MDT_RUN;
                            status <= 1'b1;
                            if (counter == 16'h0000) begin
                                counter <= timer_reload_value;
                            end
                        end
                    end
                    MDT_RUN: begin
                        if (uflow && stop_on_underflow) begin
                            state   <= MDT_HALTING;
                            counter <= 16'h0000;
                            settle  <= 32'(SETTLE_CYC - 1);
                        end else if (uflow) begin
                            counter <= timer_reload_value;
                        end else if (!enable) begin
                            state  <= MDT_IDLE;
                            status <= 1'b0;
                        end else if (tick) begin
                            counter <= counter - 16'h0001;
                        end
                    end
                    MDT_HALTING: begin
                        if (settled) begin
                            state  <= MDT_IDLE;
                            status <= 1'b0;
                        end else begin
                            settle <= settle - 32'h1;
                        end
                    end
                    MDT_RESETTING: begin
                        if (settled) begin
                            state     <= MDT_IDLE;
                            reset_bit <= 1'b0;
                        end else begin
                            settle <= settle - 32'h1;
                        end
                    end
                    default: state <= MDT_IDLE;
                endcase
            end
        end
    end

    // The flag rises only once the halt has settled in stop mode, so
    // software seeing the flag also sees status low.
    wire flag_set = (uflow && !stop_on_underflow)
                    || (state == MDT_HALTING && settled);

    // Sticky flag; a set in the same cycle as a clear wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            underflow_flag       <= 1'b0;
            timer_irq_indication <= 1'b0;
            timer_live_count     <= `MDT_LIVE_RST;
        end else if (ce) begin
            if (flag_set) begin
                underflow_flag       <= 1'b1;
                timer_irq_indication <= 1'b1;
            end else if (ev_clear && pready) begin
                underflow_flag       <= 1'b0;
                timer_irq_indication <= 1'b0;
            end
            timer_live_count <= counter;
        end
    end
endmodule
`default_nettype wire

// *** sim/mdt_timer_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mdt_defines.svh"
module mdt_timer_props (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                pready,
    input wire logic [31:0]         prdata,
    input wire logic                pslverr,
    input wire mdt_pkg::mdt_count_t timer_live_count,
    input wire logic                timer_irq_indication
);
    import mdt_pkg::*;
    logic mapped;
    logic clr_evt;
    logic wr_ctl;
    // Decoded completed transfers; a flag clear needs bit 0 set in the data.
    assign mapped  = paddr inside {`MDT_ADDR_RELOAD, `MDT_ADDR_EVENT,
                                   `MDT_ADDR_CONTROL, `MDT_ADDR_LIVE};
    assign clr_evt = pready && pwrite && paddr == `MDT_ADDR_EVENT && pwdata[0];
    assign wr_ctl  = pready && pwrite && paddr == `MDT_ADDR_CONTROL;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // The answer is a single-cycle pulse inside the access phase.
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
    property p_rdy_first; psel && penable && !$past(penable) |-> pready;
    endproperty
    a_rdy_first: assert property (p_rdy_first) else $error("pready late");
    property p_rdy_acc; pready |-> psel && penable; endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");
    // Error only for holes in the map, and such reads return zero.
    property p_err_map; pready |-> pslverr == !mapped; endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr wrong");
    property p_err_data; pready && pslverr |-> prdata == 32'h0; endproperty
    a_err_data: assert property (p_err_data) else $error("error read nonzero");
    property p_irq_hold;
        timer_irq_indication && !clr_evt |=> timer_irq_indication;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    property p_irq_fall; $fell(timer_irq_indication) |-> $past(clr_evt);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
    property p_irq_rise; $rose(timer_irq_indication) |->
        timer_live_count <= 16'h1 || $past(timer_live_count) <= 16'h1;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq no uflow");
    // A count moves by one step down unless it underflowed or was loaded.
    property p_live_step; !$stable(timer_live_count) |->
        timer_live_count == $past(timer_live_count) - 16'h1 ||
        $past(timer_live_count, 2) == 16'h1 ||
        $past(wr_ctl, 2) || $past(wr_ctl, 3);
    endproperty
    a_live_step: assert property (p_live_step) else $error("bad step");
endmodule
bind mdt_timer mdt_timer_props mdt_timer_props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .timer_live_count(timer_live_count),
    .timer_irq_indication(timer_irq_indication));
`default_nettype wire

// *** sim/mdt_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mdt_defines.svh"
module mdt_timer_tb;
    import mdt_pkg::*;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic        irq, last_err, irq_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  pstrb;
    mdt_count_t  live;
    int          num_errors = 0;
    int          checks = 0;
    mdt_timer #(.TICK_CYC(10), .SETTLE_CYC(5)) mdt_timer_i (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .timer_live_count(live), .timer_irq_indication(irq));
    // 40 MHz bus clock.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    // One APB transfer; the answer is taken at the rising edge where pready
    // is seen high, and only then is the request released.  The irq level is
    // kept from the edge at which the slave latches its read data.
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        irq_seen = irq;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input string s);
        xfer(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask
    // Polls control until the masked bits settle; bounded so a hang shows.
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        xfer(1'b0, `MDT_ADDR_CONTROL, 32'h0);
        while ((q & m) !== v && n < 40) begin
            if (q[0] === 1'b0 && q[7] === 1'b1)
                chk("early flag", 0, irq_seen);
            n++;
            xfer(1'b0, `MDT_ADDR_CONTROL, 32'h0);
        end
        chk("settle", v, q & m);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        ce = 1'b1;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`MDT_ADDR_RELOAD, 32'hffff, "reload");
        rd(`MDT_ADDR_LIVE, 32'h0, "live");
        rd(`MDT_ADDR_CONTROL, 32'h0, "control");
        rd(`MDT_ADDR_EVENT, 32'h0, "event");
        rd(12'h0f0, 32'h0, "unmapped");
        chk("slverr", 1, last_err);
        $display("test reset values done");
        xfer(1'b1, `MDT_ADDR_RELOAD, 32'h0);
        rd(`MDT_ADDR_RELOAD, 32'hffff, "zero reload");
        xfer(1'b1, `MDT_ADDR_RELOAD, 32'h3);
        xfer(1'b1, `MDT_ADDR_LIVE, 32'h55);
        rd(`MDT_ADDR_LIVE, 32'h0, "live ro");
        xfer(1'b1, `MDT_ADDR_CONTROL, 32'h1);
        rd(`MDT_ADDR_CONTROL, 32'h81, "running");
        for (int n = 0; n < 100 && irq !== 1'b1; n++) @(negedge pclk);
        chk("irq", 1, irq);
        rd(`MDT_ADDR_CONTROL, 32'h81, "free run");
        xfer(1'b1, `MDT_ADDR_CONTROL, 32'h0);
        rd(`MDT_ADDR_CONTROL, 32'h0, "stopped");
        xfer(1'b1, `MDT_ADDR_EVENT, 32'h0);
        rd(`MDT_ADDR_EVENT, 32'h1, "flag kept");
        xfer(1'b1, `MDT_ADDR_EVENT, 32'h1);
        rd(`MDT_ADDR_EVENT, 32'h0, "flag clear");
        repeat (40) @(posedge pclk);
        chk("idle irq", 0, irq);
        $display("test free run done");
        xfer(1'b1, `MDT_ADDR_CONTROL, 32'h2);
        rd(`MDT_ADDR_CONTROL, 32'h2, "reset bit");
        poll(32'hff, 32'h0);
        rd(`MDT_ADDR_LIVE, 32'h3, "reloaded");
        xfer(1'b1, `MDT_ADDR_CONTROL, 32'h5);
        poll(32'h81, 32'h0);
        chk("late irq", 1, irq);
        rd(`MDT_ADDR_CONTROL, 32'h4, "auto stop");
        rd(`MDT_ADDR_LIVE, 32'h0, "halted");
        xfer(1'b1, `MDT_ADDR_EVENT, 32'h1);
        $display("test stop on underflow done");
        final_report;
    end
    // Whole run needs well under a thousand cycles.
    initial begin
        repeat (4000) @(posedge pclk);
        num_errors++;
        final_report;
    end
endmodule
`default_nettype wire
